// File: include/eivs_pkg.sv
package eivs_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] MCU_CONTROL_IDX = 8'h35;
  localparam logic [7:0] EXT_SENSE_CONFIG_IDX = 8'h69;
  localparam logic [7:0] EXT_IRQ_MASK_IDX = 8'h1d;
  localparam logic [7:0] EXT_IRQ_FLAGS_IDX = 8'h1c;
  localparam logic [7:0] PC_ENABLE_IDX = 8'h68;
  localparam logic [7:0] PC_FLAGS_IDX = 8'h1b;
  localparam logic [7:0] PIN_CHANGE_MASK0_IDX = 8'h6b;
  localparam logic [7:0] PIN_CHANGE_MASK1_IDX = 8'h6c;
  localparam logic [7:0] PIN_CHANGE_MASK2_IDX = 8'h6d;

  // mcu_control field positions
  localparam int UNLOCK_BIT = 0;
  localparam int TABLE_SEL_BIT = 1;
  localparam int PULLUP_OFF_BIT = 4;

  localparam logic [7:0] REG_RESET = 8'h00;

  // unlock window in cpu cycles
  localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;

  // sense select codes per dedicated pin
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // vector numbers of the sources handled here
  localparam logic [4:0] VEC_EXT0 = 5'h01;
  localparam logic [4:0] VEC_EXT1 = 5'h02;
  localparam logic [4:0] VEC_PC0 = 5'h03;
  localparam logic [4:0] VEC_PC1 = 5'h04;
  localparam logic [4:0] VEC_PC2 = 5'h05;
  localparam logic [4:0] VEC_NONE = 5'h00;

  // last program memory word address and boot section sizes in words
  localparam logic [13:0] FLASH_LAST_WORD = 14'h3fff;
  localparam logic [13:0] BOOT_WORDS_SEL0 = 14'h0800;
  localparam logic [13:0] BOOT_WORDS_SEL1 = 14'h0400;
  localparam logic [13:0] BOOT_WORDS_SEL2 = 14'h0200;
  localparam logic [13:0] BOOT_WORDS_SEL3 = 14'h0100;
  localparam logic [13:0] APP_BASE = 14'h0000;

  typedef struct packed {
    logic bootResetSelect;
    logic [1:0] bootSizeSelect;
    logic appSideBootLock;
    logic bootSideBootLock;
  } eivs_fuse_type;

  typedef struct packed {
    logic pending;
    logic [4:0] vector;
    logic [13:0] address;
  } eivs_irq_type;

endpackage : eivs_pkg

// File: rtl/eivs_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; only the second stage is visible outside
module eivs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end

endmodule : eivs_sync

// File: rtl/eivs_top.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module eivs_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire eivs_pkg::eivs_fuse_type fuses,
  input wire logic globalIrqEnable,
  input wire logic execInBoot,
  input wire logic instrRetire,
  input wire logic irqAck,
  input wire logic [4:0] ackVector,
  input wire logic ioClockRunning,
  input wire logic [1:0] extIrqPin,
  input wire logic [23:0] pinChangeInputs,
  output eivs_pkg::eivs_irq_type irqOut,
  output logic irqBlocked,
  output logic [13:0] resetVector,
  output logic wakeRequest,
  output logic pullupDisable
);

  localparam int NGROUP = 3;

  logic [1:0] extSync;
  logic [23:0] pcSync;
  eivs_pkg::eivs_fuse_type fuseSync;
  logic [1:0] extPrev_q;
  logic [23:0] pcPrev_q;

  logic tableSel_q;
  logic unlock_q;
  logic [2:0] unlockCnt_q;
  logic followBlock_q;
  logic pullupOff_q;
  logic [3:0] senseCfg_q;
  logic [1:0] extMask_q;
  logic [1:0] extFlag_q;
  logic [2:0] pcEnable_q;
  logic [2:0] pcFlag_q;
  logic [7:0] pcMask_q [NGROUP];

  logic setupPhase;
  logic writeAccess;
  logic [7:0] regIdx;
  logic idxMapped;
  logic [7:0] readMux;
  logic wrMcu;
  logic wrSense;
  logic wrExtMask;
  logic wrExtFlag;
  logic wrPcEn;
  logic wrPcFlag;

  logic [1:0] extEdge;
  logic [1:0] extLevelReq;
  logic [2:0] pcChange;
  logic [4:0] reqVec;
  logic [13:0] bootBase;
  logic [13:0] vecBase;
  logic lockBlock;
  logic blockNow;
  logic [4:0] selVector;

  // fuses are straps from another domain, so they are synchronised too
  eivs_sync #(.WIDTH(2 + 24 + $bits(eivs_pkg::eivs_fuse_type))) u_sync (
    .clock(clock),
    .reset(reset),
    .asyncIn({extIrqPin, pinChangeInputs, fuses}),
    .syncOut({extSync, pcSync, fuseSync})
  );

  // ---------------- register bus ----------------
  assign setupPhase = psel & ~penable;
  assign writeAccess = psel & penable & pready & pwrite;
  assign regIdx = paddr[9:2];

  always_comb begin
    idxMapped = 1'b1;
    readMux = 8'h00;
    case (regIdx)
      eivs_pkg::MCU_CONTROL_IDX: begin
        readMux[eivs_pkg::UNLOCK_BIT] = unlock_q;
        readMux[eivs_pkg::TABLE_SEL_BIT] = tableSel_q;
        readMux[eivs_pkg::PULLUP_OFF_BIT] = pullupOff_q;
      end
      eivs_pkg::EXT_SENSE_CONFIG_IDX: readMux = {4'h0, senseCfg_q};
      eivs_pkg::EXT_IRQ_MASK_IDX: readMux = {6'h00, extMask_q};
      eivs_pkg::EXT_IRQ_FLAGS_IDX: readMux = {6'h00, extFlag_q};
      eivs_pkg::PC_ENABLE_IDX: readMux = {5'h00, pcEnable_q};
      eivs_pkg::PC_FLAGS_IDX: readMux = {5'h00, pcFlag_q};
      eivs_pkg::PIN_CHANGE_MASK0_IDX: readMux = pcMask_q[0];
      eivs_pkg::PIN_CHANGE_MASK1_IDX: readMux = {1'b0, pcMask_q[1][6:0]};
      eivs_pkg::PIN_CHANGE_MASK2_IDX: readMux = pcMask_q[2];
      default: idxMapped = 1'b0;
    endcase
  end

  // answer comes in the first access cycle; data and error are settled at setup
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        // refused reads return zero, like writes
        prdata <= (pwrite | ~idxMapped | (paddr[1:0] != 2'h0)) ? 32'h0000_0000 : {24'h00_0000, readMux};
        pslverr <= ~idxMapped | (paddr[1:0] != 2'h0);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  assign wrMcu = writeAccess & ~pslverr & (regIdx == eivs_pkg::MCU_CONTROL_IDX);
  assign wrSense = writeAccess & ~pslverr & (regIdx == eivs_pkg::EXT_SENSE_CONFIG_IDX);
  assign wrExtMask = writeAccess & ~pslverr & (regIdx == eivs_pkg::EXT_IRQ_MASK_IDX);
  assign wrExtFlag = writeAccess & ~pslverr & (regIdx == eivs_pkg::EXT_IRQ_FLAGS_IDX);
  assign wrPcEn = writeAccess & ~pslverr & (regIdx == eivs_pkg::PC_ENABLE_IDX);
  assign wrPcFlag = writeAccess & ~pslverr & (regIdx == eivs_pkg::PC_FLAGS_IDX);

  // ---------------- vector table select sequence ----------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      unlock_q <= 1'b0;
      unlockCnt_q <= 3'h0;
      tableSel_q <= 1'b0;
    end else if (wrMcu && pwdata[eivs_pkg::UNLOCK_BIT]) begin
      // a fresh unlock write restarts the window
      unlock_q <= 1'b1;
      unlockCnt_q <= eivs_pkg::UNLOCK_WINDOW_CYC;
    end else if (wrMcu && unlock_q) begin
      tableSel_q <= pwdata[eivs_pkg::TABLE_SEL_BIT];
      unlock_q <= 1'b0;
      unlockCnt_q <= 3'h0;
    end else if (unlock_q) begin
      unlockCnt_q <= unlockCnt_q - 3'h1;
      if (unlockCnt_q == 3'h1) begin
        unlock_q <= 1'b0;
      end
    end
  end

  // keeps interrupts off until the instruction after the select write retires
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      followBlock_q <= 1'b0;
    end else if (wrMcu && unlock_q && !pwdata[eivs_pkg::UNLOCK_BIT]) begin
      followBlock_q <= 1'b1;
    end else if (instrRetire) begin
      followBlock_q <= 1'b0;
    end
  end

  // bits of mcu_control that are not part of the unlock sequence
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pullupOff_q <= 1'b0;
    end else if (wrMcu) begin
      pullupOff_q <= pwdata[eivs_pkg::PULLUP_OFF_BIT];
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      senseCfg_q <= eivs_pkg::REG_RESET[3:0];
      extMask_q <= eivs_pkg::REG_RESET[1:0];
      pcEnable_q <= eivs_pkg::REG_RESET[2:0];
    end else begin
      if (wrSense) begin
        senseCfg_q <= pwdata[3:0];
      end
      if (wrExtMask) begin
        extMask_q <= pwdata[1:0];
      end
      if (wrPcEn) begin
        pcEnable_q <= pwdata[2:0];
      end
    end
  end

  // ---------------- pin-change groups ----------------
  generate
    for (genvar g = 0; g < NGROUP; g++) begin : g_pc
      logic [7:0] changed;
      logic wrMask;
      logic ackThis;
      assign wrMask = writeAccess & ~pslverr & (regIdx == eivs_pkg::PIN_CHANGE_MASK0_IDX + 8'(g));
      // a toggle against the previous synchronised sample, on unmasked inputs only
      assign changed = (pcSync[8*g +: 8] ^ pcPrev_q[8*g +: 8]) & pcMask_q[g];
      assign pcChange[g] = |changed;
      assign ackThis = irqAck & (ackVector == eivs_pkg::VEC_PC0 + 5'(g));

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          pcMask_q[g] <= eivs_pkg::REG_RESET;
        end else if (wrMask) begin
          // input 15 does not exist, so its mask bit is held at zero
          pcMask_q[g] <= (g == 1) ? {1'b0, pwdata[6:0]} : pwdata[7:0];
        end
      end

      // set wins over both ways of clearing
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          pcFlag_q[g] <= 1'b0;
        end else if (pcChange[g]) begin
          pcFlag_q[g] <= 1'b1;
        end else if (ackThis || (wrPcFlag && pwdata[g])) begin
          pcFlag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------- dedicated external pins ----------------
  generate
    for (genvar p = 0; p < 2; p++) begin : g_ext
      logic [1:0] sense;
      logic ackThis;
      assign sense = senseCfg_q[2*p +: 2];
      assign ackThis = irqAck & (ackVector == eivs_pkg::VEC_EXT0 + 5'(p));

      always_comb begin
        case (sense)
          eivs_pkg::SENSE_ANY: extEdge[p] = extSync[p] ^ extPrev_q[p];
          eivs_pkg::SENSE_FALL: extEdge[p] = extPrev_q[p] & ~extSync[p];
          eivs_pkg::SENSE_RISE: extEdge[p] = ~extPrev_q[p] & extSync[p];
          default: extEdge[p] = 1'b0;
        endcase
      end

      // live request that lasts only as long as the pin is low
      assign extLevelReq[p] = (sense == eivs_pkg::SENSE_LOW) & ~extSync[p] & extMask_q[p];

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          extFlag_q[p] <= 1'b0;
        end else if (sense == eivs_pkg::SENSE_LOW) begin
          extFlag_q[p] <= 1'b0;
        end else if (extEdge[p] && ioClockRunning) begin
          extFlag_q[p] <= 1'b1;
        end else if (ackThis || (wrExtFlag && pwdata[p])) begin
          extFlag_q[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // previous samples always track, so a stopped io clock leaves no stale edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      extPrev_q <= 2'h0;
      pcPrev_q <= 24'h00_0000;
    end else begin
      extPrev_q <= extSync;
      pcPrev_q <= pcSync;
    end
  end

  // ---------------- request arbitration and vector address ----------------
  assign reqVec[0] = (extFlag_q[0] & extMask_q[0]) | extLevelReq[0];
  assign reqVec[1] = (extFlag_q[1] & extMask_q[1]) | extLevelReq[1];
  assign reqVec[4:2] = pcFlag_q & pcEnable_q;

  always_comb begin
    selVector = eivs_pkg::VEC_NONE;
    for (int i = 4; i >= 0; i--) begin
      if (reqVec[i]) begin
        selVector = eivs_pkg::VEC_EXT0 + 5'(i);
      end
    end
  end

  always_comb begin
    case (fuseSync.bootSizeSelect)
      2'h0: bootBase = eivs_pkg::FLASH_LAST_WORD - eivs_pkg::BOOT_WORDS_SEL0 + 14'h0001;
      2'h1: bootBase = eivs_pkg::FLASH_LAST_WORD - eivs_pkg::BOOT_WORDS_SEL1 + 14'h0001;
      2'h2: bootBase = eivs_pkg::FLASH_LAST_WORD - eivs_pkg::BOOT_WORDS_SEL2 + 14'h0001;
      default: bootBase = eivs_pkg::FLASH_LAST_WORD - eivs_pkg::BOOT_WORDS_SEL3 + 14'h0001;
    endcase
  end

  assign vecBase = tableSel_q ? bootBase : eivs_pkg::APP_BASE;

  // a protected section may never jump into vectors held by the other one
  assign lockBlock = tableSel_q ? (fuseSync.appSideBootLock & ~execInBoot)
                                : (fuseSync.bootSideBootLock & execInBoot);
  assign blockNow = unlock_q | followBlock_q | lockBlock;

  // the global enable is only read; the automatic block is a separate gate
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irqOut <= '0;
      irqBlocked <= 1'b0;
    end else begin
      irqBlocked <= blockNow | (wrMcu & pwdata[eivs_pkg::UNLOCK_BIT]);
      irqOut.pending <= (selVector != eivs_pkg::VEC_NONE) & globalIrqEnable & ~blockNow
                        & ~(wrMcu & pwdata[eivs_pkg::UNLOCK_BIT]) & ~irqAck;
      irqOut.vector <= selVector;
      irqOut.address <= vecBase + {8'h00, selVector, 1'b0};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      resetVector <= 14'h0000;
      wakeRequest <= 1'b0;
      pullupDisable <= 1'b0;
    end else begin
      resetVector <= fuseSync.bootResetSelect ? bootBase : eivs_pkg::APP_BASE;
      // only pin change and low level may wake; edges need the io clock
      wakeRequest <= (|(pcChange & pcEnable_q)) | (|extLevelReq);
      pullupDisable <= pullupOff_q;
    end
  end

endmodule : eivs_top

// File: testbench/eivs_core_model.sv
`timescale 1ns/1ps
// core side: enters the handler ackDelay + 1 cycles after a request shows
module eivs_core_model (
  input wire logic clock,
  input wire logic reset,
  input wire eivs_pkg::eivs_irq_type irq,
  input wire logic [3:0] ackDelay,
  output logic irqAck,
  output logic [4:0] ackVector,
  output logic [13:0] lastAddr,
  output logic [7:0] ackCount
);
  logic [3:0] wait_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_q <= 4'h0;
      irqAck <= 1'b0;
      ackVector <= 5'h00;
      lastAddr <= 14'h0000;
      ackCount <= 8'h00;
    end else if (irq.pending && !irqAck && wait_q == ackDelay) begin
      irqAck <= 1'b1;
      ackVector <= irq.vector;
      lastAddr <= irq.address;
      ackCount <= ackCount + 8'h01;
      wait_q <= 4'h0;
    end else begin
      irqAck <= 1'b0;
      wait_q <= irq.pending ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : eivs_core_model

// File: testbench/eivs_monitor.sv
`timescale 1ns/1ps
module eivs_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire eivs_pkg::eivs_fuse_type fuses,
  input wire logic globalIrqEnable,
  input wire eivs_pkg::eivs_irq_type irqOut,
  input wire logic irqBlocked,
  input wire logic [13:0] resetVector,
  input wire logic pullupDisable
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic mcuWr = psel && penable && pready && pwrite && paddr == 12'h0d4;
  wire logic [13:0] bootBase = 14'h3fff - (14'h07ff >> fuses.bootSizeSelect);
  a_pready_first: assert property (psel && !penable |=> pready) else $error("no answer in access cycle");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error with data");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_unlock_block: assert property (mcuWr && pwdata[0] |=> irqBlocked) else $error("unlock not blocking");
  a_block_mask: assert property (irqBlocked && $past(irqBlocked) |-> !irqOut.pending)
    else $error("request while blocked");
  a_enable_gate: assert property (!globalIrqEnable |=> !irqOut.pending) else $error("request while disabled");
  a_pullup_copy: assert property (mcuWr |-> ##2 pullupDisable == $past(pwdata[4], 2)) else $error("pull-up bit");
  a_vector_addr: assert property (irqOut.pending |-> irqOut.address == {8'h00, irqOut.vector, 1'b0} ||
    irqOut.address == bootBase + {8'h00, irqOut.vector, 1'b0}) else $error("vector address");
  // straps pass two sync stages and the output register, so compare against their value three edges back
  a_reset_vec: assert property ((!reset)[*5] |-> resetVector == ($past(fuses.bootResetSelect, 3) ?
    14'h3fff - (14'h07ff >> $past(fuses.bootSizeSelect, 3)) : 14'h0)) else $error("reset vector");
endmodule : eivs_monitor
bind eivs_top eivs_monitor eivs_monitor_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fuses(fuses), .globalIrqEnable(globalIrqEnable), .irqOut(irqOut), .irqBlocked(irqBlocked),
  .resetVector(resetVector), .pullupDisable(pullupDisable));

// File: testbench/eivs_top_test.sv
`timescale 1ns/1ps
module eivs_top_test;
  localparam logic [7:0] MCU = eivs_pkg::MCU_CONTROL_IDX;
  localparam logic [7:0] EFLG = eivs_pkg::EXT_IRQ_FLAGS_IDX;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, gie, execInBoot, instrRetire, irqAck;
  logic ioClk, irqBlocked, wakeRequest, pullupDisable, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [4:0] ackVector;
  logic [1:0] extIrqPin;
  logic [23:0] pc;
  logic [13:0] resetVector, lastAddr;
  logic [7:0] ackCount, n0;
  logic [3:0] ackDelay;
  eivs_pkg::eivs_fuse_type fuses;
  eivs_pkg::eivs_irq_type irqOut;
  int fails, nTests;
  eivs_top eivs_top_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuses(fuses),
    .globalIrqEnable(gie), .execInBoot(execInBoot), .instrRetire(instrRetire), .irqAck(irqAck),
    .ackVector(ackVector), .ioClockRunning(ioClk), .extIrqPin(extIrqPin), .pinChangeInputs(pc),
    .irqOut(irqOut), .irqBlocked(irqBlocked), .resetVector(resetVector), .wakeRequest(wakeRequest),
    .pullupDisable(pullupDisable));
  eivs_core_model eivs_core_model_i (.clock(clock), .reset(reset), .irq(irqOut), .ackDelay(ackDelay),
    .irqAck(irqAck), .ackVector(ackVector), .lastAddr(lastAddr), .ackCount(ackCount));
  always #2.5 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) fails++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask : settle
  task automatic retire();
    instrRetire <= 1'b1;
    settle(1);
    instrRetire <= 1'b0;
    settle(3);
  endtask : retire
  // a hang anywhere is cut short here
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    clock = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; fuses = 5'h14;
    gie = 0; execInBoot = 0; instrRetire = 0; ioClk = 1; extIrqPin = 2'h3; pc = 24'h0; ackDelay = 4'h2;
    settle(16);
    reset <= 1'b0;
    settle(6);
    check(resetVector, 14'h3c00);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i < 3 ? 8'h1b + i : (i < 5 ? 8'h68 + i - 3 : 8'h6b + i - 5)));
      check({errv, rdv[30:0]}, 32'h0);
    end
    rd(MCU);
    check(rdv, 32'h0);
    rd(8'hff);
    check({errv, rdv[30:0]}, 32'h80000000);
    wr(MCU, 8'h12);
    rd(MCU);
    check({pullupDisable, rdv[30:0]}, 32'h80000010);
    wr(MCU, 8'h01);
    check(irqBlocked, 1'b1);
    wr(MCU, 8'h02);
    rd(MCU);
    check(rdv, 32'h02);
    settle(8);
    check(irqBlocked, 1'b1);
    retire();
    check(irqBlocked, 1'b0);
    wr(MCU, 8'h01);
    settle(6);
    check(irqBlocked, 1'b0);
    wr(MCU, 8'h00);
    rd(MCU);
    check(rdv, 32'h02);
    gie <= 1'b1;
    wr(eivs_pkg::EXT_SENSE_CONFIG_IDX, 8'h02);
    wr(eivs_pkg::EXT_IRQ_MASK_IDX, 8'h01);
    extIrqPin <= 2'h2;
    settle(12);
    check({ackVector, lastAddr}, {eivs_pkg::VEC_EXT0, 14'h3c02});
    wr(MCU, 8'h01);
    wr(MCU, 8'h00);
    retire();
    extIrqPin <= 2'h3;
    settle(6);
    extIrqPin <= 2'h2;
    settle(12);
    check(lastAddr, 14'h0002);
    gie <= 1'b0;
    extIrqPin <= 2'h3;
    for (int c = 0; c < 4; c++) begin
      wr(eivs_pkg::EXT_SENSE_CONFIG_IDX, 8'(c));
      wr(EFLG, 8'h01);
      extIrqPin <= 2'h2;
      settle(6);
      rd(EFLG);
      check(rdv, 32'(c == 1 || c == 2));
      wr(EFLG, 8'h01);
      extIrqPin <= 2'h3;
      settle(6);
      rd(EFLG);
      check(rdv, 32'(c % 2));
      wr(EFLG, 8'h01);
    end
    ioClk <= 1'b0;
    wr(eivs_pkg::EXT_SENSE_CONFIG_IDX, 8'h02);
    extIrqPin <= 2'h2;
    settle(6);
    rd(EFLG);
    check(rdv, 32'h0);
    ioClk <= 1'b1;
    extIrqPin <= 2'h3;
    wr(eivs_pkg::EXT_SENSE_CONFIG_IDX, 8'h00);
    gie <= 1'b1;
    n0 = ackCount;
    // level held well past the handler entries so each one is recognised
    extIrqPin <= 2'h2;
    settle(40);
    check(32'(ackCount - n0 > 8'h2), 32'h1);
    check(wakeRequest, 1'b1);
    extIrqPin <= 2'h3;
    gie <= 1'b0;
    fuses <= 5'h15;
    execInBoot <= 1'b1;
    settle(6);
    check(irqBlocked, 1'b1);
    check(wakeRequest, 1'b0);
    execInBoot <= 1'b0;
    settle(4);
    check(irqBlocked, 1'b0);
    fuses <= 5'h14;
    wr(eivs_pkg::PC_ENABLE_IDX, 8'h07);
    for (int g = 0; g < 3; g++) begin
      wr(8'(eivs_pkg::PIN_CHANGE_MASK0_IDX + g), 8'h01);
      pc <= pc ^ (24'h2 << 8 * g);
      settle(6);
      rd(eivs_pkg::PC_FLAGS_IDX);
      check(rdv, 32'h0);
      pc <= pc ^ (24'h1 << 8 * g);
      settle(6);
      rd(eivs_pkg::PC_FLAGS_IDX);
      check(rdv, 32'h1 << g);
      wr(eivs_pkg::PC_FLAGS_IDX, 8'h07);
    end
    // largest boot section moves the boot base down
    fuses <= 5'h10;
    settle(6);
    check(resetVector, 14'h3800);
    results();
  end
endmodule : eivs_top_test
